// ==== hw/modbus_slave_local_regs_delay.sv ====
// Modbus slave local registers, drive forwarding, LEDs and response delay
//
// How it works
// - Delay setting in 10 ms steps, 0..2.00 s.
// - Zero delay sends response once assembled.
// - Nonzero delay timed from complete request packet.
// - Delay setting sampled only at initialization.
// - Bad station number flashes module LED red.
// - Faulty packet briefly flashes network LED red.
// - Pointer data at 0x0C00/0xFC00, target permissions.
// - Pointer address RW, values 0x0001..0xFFFF.
// - Firmware word read-only: version high, revision low.
// - Other addresses except 0x0000 forwarded to drive registers.
// - Drive register is Modbus number minus one, with 0xF000 ORed in for 0x0C40..0x0FFF.
// - Pointer data uses same-index address, 32 pairs.
// - Pointer addresses act at once, persisted.
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_local_regs_delay import mb_local_pkg::*; #(
  parameter int STEP_CYCLES_P = STEP_CYCLES,
  parameter logic [7:0] FW_VERSION = 8'h01, // Arbitrary value
  parameter logic [7:0] FW_REVISION = 8'h00 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Drive parameters, sampled at initialization
  input wire logic [7:0] response_delay_setting,
  input wire logic [7:0] station_number_setting,
  // Packet events from the Modbus engine
  input wire logic frame_done,
  input wire logic bad_packet,
  input wire logic rsp_avail,
  output logic tx_start,
  // Register request from the Modbus engine
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_rdata,
  // Drive register access
  output logic drv_req_valid,
  output logic drv_req_write,
  output logic [15:0] drv_req_addr,
  output logic [15:0] drv_req_wdata,
  input wire logic drv_rsp_valid,
  input wire logic drv_rsp_error,
  input wire logic [15:0] drv_rsp_rdata,
  // Nonvolatile pointer address store
  input wire logic ptr_restore_valid,
  input wire logic [4:0] ptr_restore_idx,
  input wire logic [15:0] ptr_restore_data,
  output logic nvm_wr_valid,
  output logic [4:0] nvm_wr_idx,
  output logic [15:0] nvm_wr_data,
  // Status LEDs
  output logic mod_led_red,
  output logic net_led_red
);
  ctl_state_e state_q;
  logic [7:0] delay_q, station_q;
  logic cfg_err_q;
  logic [15:0] ptr_tab [PTR_COUNT];
  logic rsp_valid_q, rsp_error_q;
  logic [15:0] rsp_rdata_q;
  logic drv_valid_q, drv_write_q;
  logic [15:0] drv_addr_q, drv_wdata_q;
  logic nvm_valid_q;
  logic [4:0] nvm_idx_q;
  logic [15:0] nvm_data_q;

  // Decode of the raw request: only the pointer data window matters here
  wire raw_local = (req_addr[15:12] == NIB_LOW) || (req_addr[15:12] == NIB_ALIAS);
  wire raw_pdata = raw_local && (req_addr[11:0] >= PTR_DATA_LO)
                   && (req_addr[11:0] <= PTR_DATA_HI);
  wire [15:0] eff_addr = raw_pdata ? ptr_tab[req_addr[4:0]] : req_addr;

  // Decode of the effective address
  wire eff_local = (eff_addr[15:12] == NIB_LOW) || (eff_addr[15:12] == NIB_ALIAS);
  wire eff_pdata = eff_local && (eff_addr[11:0] >= PTR_DATA_LO)
                   && (eff_addr[11:0] <= PTR_DATA_HI);
  wire eff_paddr = eff_local && (eff_addr[11:0] >= PTR_ADDR_LO)
                   && (eff_addr[11:0] <= PTR_ADDR_HI);
  wire eff_fw = eff_local && (eff_addr[11:0] == FW_WORD_OFS);
  wire eff_zero = (eff_addr == MB_ZERO);
  wire redir = (eff_addr[15:12] == NIB_LOW) && (eff_addr[11:0] >= REDIR_LO)
               && !eff_fw;
  // A pointer aimed at the data window would recurse, so an access through it is refused
  wire loc_err = eff_pdata || eff_zero || (eff_fw && req_write)
                 || (eff_paddr && req_write && req_wdata == MB_ZERO);
  wire to_drive = !loc_err && !eff_paddr && !eff_fw;
  wire [15:0] drv_addr_d = (eff_addr - MB_ONE) | (redir ? UPPER_MASK : MB_ZERO);
  wire [15:0] fw_word = {FW_VERSION, FW_REVISION};
  wire [15:0] loc_data = (req_write || loc_err) ? MB_ZERO
                         : eff_fw ? fw_word : ptr_tab[eff_addr[4:0]];
  wire take = req_valid && (state_q == ST_IDLE);
  wire host_we = take && eff_paddr && req_write && !loc_err;
  wire tab_we = host_we || ptr_restore_valid;
  wire [4:0] tab_idx = host_we ? eff_addr[4:0] : ptr_restore_idx;
  wire [15:0] tab_wd = host_we ? req_wdata : ptr_restore_data;
  wire [7:0] delay_sat = (response_delay_setting > DELAY_MAX_STEPS)
                         ? DELAY_MAX_STEPS : response_delay_setting;
  wire station_bad = (station_number_setting < STATION_MIN)
                     || (station_number_setting > STATION_MAX);

  assign req_ready = (state_q == ST_IDLE);

  // Pointer address table, written at once by the host or restored
  for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        ptr_tab[i] <= MB_ZERO;
      end else if (tab_we && tab_idx == 5'(i)) begin
        ptr_tab[i] <= tab_wd;
      end
    end
  end

  // Settings are frozen in the cycle after reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_INIT;
      delay_q <= 8'(DELAY_DEFAULT_MS / DELAY_STEP_MS);
      station_q <= 8'h00;
      cfg_err_q <= 1'b0;
    end else begin
      case (state_q)
        ST_INIT: begin
          delay_q <= delay_sat;
          station_q <= station_number_setting;
          cfg_err_q <= station_bad;
          state_q <= ST_IDLE;
        end
        ST_IDLE: state_q <= (take && to_drive) ? ST_DRIVE : ST_IDLE;
        ST_DRIVE: state_q <= drv_rsp_valid ? ST_IDLE : ST_DRIVE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_rdata_q <= MB_ZERO;
    end else begin
      rsp_valid_q <= (take && !to_drive) || (state_q == ST_DRIVE && drv_rsp_valid);
      if (take && !to_drive) begin
        rsp_error_q <= loc_err;
        rsp_rdata_q <= loc_data;
      end else if (state_q == ST_DRIVE && drv_rsp_valid) begin
        rsp_error_q <= drv_rsp_error;
        rsp_rdata_q <= drv_rsp_error ? MB_ZERO : drv_rsp_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drv_valid_q <= 1'b0;
      drv_write_q <= 1'b0;
      drv_addr_q <= MB_ZERO;
      drv_wdata_q <= MB_ZERO;
    end else begin
      drv_valid_q <= take && to_drive;
      if (take && to_drive) begin
        drv_write_q <= req_write;
        drv_addr_q <= drv_addr_d;
        drv_wdata_q <= req_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvm_valid_q <= 1'b0;
      nvm_idx_q <= 5'h00;
      nvm_data_q <= MB_ZERO;
    end else begin
      nvm_valid_q <= host_we;
      if (host_we) begin
        nvm_idx_q <= eff_addr[4:0];
        nvm_data_q <= req_wdata;
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_error = rsp_error_q;
  assign rsp_rdata = rsp_rdata_q;
  assign drv_req_valid = drv_valid_q;
  assign drv_req_write = drv_write_q;
  assign drv_req_addr = drv_addr_q;
  assign drv_req_wdata = drv_wdata_q;
  assign nvm_wr_valid = nvm_valid_q;
  assign nvm_wr_idx = nvm_idx_q;
  assign nvm_wr_data = nvm_data_q;

  // Free running 10 ms tick for the LED timing
  localparam int PW = $clog2(STEP_CYCLES_P + 1);
  logic [PW-1:0] pre_q;
  logic [7:0] blink_cnt_q, net_cnt_q;
  logic blink_q;
  wire tick = (pre_q == PW'(STEP_CYCLES_P - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= '0;
      blink_cnt_q <= 8'h00;
      blink_q <= 1'b0;
    end else begin
      pre_q <= tick ? '0 : pre_q + PW'(1);
      if (tick) begin
        blink_cnt_q <= (blink_cnt_q == MOD_BLINK_STEPS - 8'h01) ? 8'h00 : blink_cnt_q + 8'h01;
        blink_q <= (blink_cnt_q == MOD_BLINK_STEPS - 8'h01) ? !blink_q : blink_q;
      end
    end
  end

  // A new fault restarts the flash so bursts stay visible
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      net_cnt_q <= 8'h00;
    end else if (bad_packet) begin
      net_cnt_q <= NET_FLASH_STEPS;
    end else if (tick && net_cnt_q != 8'h00) begin
      net_cnt_q <= net_cnt_q - 8'h01;
    end
  end
  assign mod_led_red = cfg_err_q && blink_q;
  assign net_led_red = (net_cnt_q != 8'h00);

  response_delay_timer #(.STEP_CYCLES_P(STEP_CYCLES_P)) u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .delay_steps(delay_q),
    .frame_done(frame_done),
    .rsp_avail(rsp_avail),
    .tx_start(tx_start)
  );

  a_delay_range: assert property (@(posedge clk) disable iff (sys_rst)
    delay_q <= DELAY_MAX_STEPS) else $error("delay beyond 2.00 s");
  a_delay_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q != ST_INIT && $past(state_q) != ST_INIT) |-> $stable(delay_q))
    else $error("delay changed after init");
  a_cfg_dark: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q != ST_INIT && station_q >= STATION_MIN && station_q <= STATION_MAX)
    |-> !mod_led_red) else $error("module LED red with good station");
  a_net_flash: assert property (@(posedge clk) disable iff (sys_rst)
    bad_packet |=> net_led_red [*8]) else $error("net LED flash missing");
  a_fw_read: assert property (@(posedge clk) disable iff (sys_rst)
    (take && !raw_pdata && req_addr[11:0] == FW_WORD_OFS && eff_local && !req_write)
    |=> rsp_valid && !rsp_error && rsp_rdata == {FW_VERSION, FW_REVISION})
    else $error("firmware word wrong");
  a_ptr_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (take && eff_paddr && req_write && req_wdata == MB_ZERO)
    |=> rsp_valid && rsp_error && !nvm_wr_valid) else $error("zero pointer accepted");
  a_drv_minus1: assert property (@(posedge clk) disable iff (sys_rst)
    (take && to_drive) |=> drv_req_valid
    && (drv_req_addr | UPPER_MASK) == (($past(eff_addr) - MB_ONE) | UPPER_MASK))
    else $error("drive address not minus one");
  a_redirect: assert property (@(posedge clk) disable iff (sys_rst)
    (take && to_drive && redir) |=> drv_req_addr[15:12] == NIB_ALIAS)
    else $error("low gap not redirected");
  a_ptr_write: assert property (@(posedge clk) disable iff (sys_rst)
    host_we |=> ptr_tab[$past(eff_addr[4:0])] == $past(req_wdata) && nvm_wr_valid)
    else $error("pointer write lost");
endmodule // modbus_slave_local_regs_delay
`default_nettype wire

// ==== hw/mb_local_pkg.sv ====
// Constants for the Modbus slave local register and response delay logic
package mb_local_pkg;
  localparam logic [3:0] NIB_LOW = 4'h0;
  localparam logic [3:0] NIB_ALIAS = 4'hf;
  localparam logic [11:0] PTR_DATA_LO = 12'h0c00;
  localparam logic [11:0] PTR_DATA_HI = 12'h0c1f;
  localparam logic [11:0] PTR_ADDR_LO = 12'h0c20;
  localparam logic [11:0] PTR_ADDR_HI = 12'h0c3f;
  localparam logic [11:0] FW_WORD_OFS = 12'h0c82;
  localparam logic [11:0] REDIR_LO = 12'h0c40;
  localparam logic [15:0] UPPER_MASK = 16'hf000;
  localparam logic [15:0] MB_ZERO = 16'h0000;
  localparam logic [15:0] MB_ONE = 16'h0001;
  localparam int PTR_COUNT = 32;
  localparam int CLK_HZ = 100_000_000;
  localparam int DELAY_STEP_MS = 10;
  localparam int DELAY_MAX_MS = 2000;
  localparam int DELAY_DEFAULT_MS = 0;
  localparam int STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam logic [7:0] DELAY_MAX_STEPS = 8'(DELAY_MAX_MS / DELAY_STEP_MS);
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hf7;
  localparam int NET_FLASH_MS = 100;
  localparam int MOD_BLINK_MS = 500;
  localparam logic [7:0] NET_FLASH_STEPS = 8'(NET_FLASH_MS / DELAY_STEP_MS);
  localparam logic [7:0] MOD_BLINK_STEPS = 8'(MOD_BLINK_MS / DELAY_STEP_MS);
  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_DRIVE = 3'b100
  } ctl_state_e;
endpackage

// ==== hw/response_delay_timer.sv ====
// Minimum response delay timer, started by a complete request packet
`timescale 1ns/1ps
`default_nettype none
module response_delay_timer import mb_local_pkg::*; #(
  parameter int STEP_CYCLES_P = STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Delay in 10 ms steps, frozen by the caller
  input wire logic [7:0] delay_steps,
  // Packet events
  input wire logic frame_done,
  input wire logic rsp_avail,
  output logic tx_start
);
  localparam int PW = $clog2(STEP_CYCLES_P + 1);
  logic [PW-1:0] pre_q;
  logic [7:0] cnt_q;
  logic run_q, pend_q, tx_q;
  wire tick = run_q && (pre_q == PW'(STEP_CYCLES_P - 1));
  wire run_end = tick && (cnt_q == 8'h01);
  // Prescaler restarts with the packet so the wait is never cut short
  wire fire = pend_q && !run_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= '0;
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else if (frame_done) begin
      pre_q <= '0;
      cnt_q <= delay_steps;
      run_q <= (delay_steps != 8'h00);
    end else if (run_q) begin
      pre_q <= tick ? '0 : pre_q + PW'(1);
      cnt_q <= tick ? cnt_q - 8'h01 : cnt_q;
      run_q <= !run_end;
    end
  end

  // New response in the firing cycle stays pending
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      pend_q <= rsp_avail || (pend_q && !fire);
      tx_q <= fire;
    end
  end
  assign tx_start = tx_q;

  logic [31:0] since_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q <= 32'h0000_0000;
    end else if (frame_done) begin
      since_q <= 32'h0000_0000;
    end else if (since_q != 32'hffff_ffff) begin
      since_q <= since_q + 32'h0000_0001;
    end
  end

  a_min_wait: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_start && run_q == 1'b0 && delay_steps != 8'h00 && since_q != 32'hffff_ffff
     && $past(pend_q)) |-> (since_q >= 32'(delay_steps) * 32'(STEP_CYCLES_P)))
    else $error("response sent before delay expired");
  a_zero_fast: assert property (@(posedge clk) disable iff (sys_rst)
    (rsp_avail && !pend_q && !run_q && !frame_done && delay_steps == 8'h00) |-> ##2 tx_start)
    else $error("zero delay response not sent at once");
endmodule // response_delay_timer
`default_nettype wire

// ==== bench/drive_reg_model.sv ====
// Drive register model answering forwarded register accesses
`timescale 1ns/1ps
`default_nettype none
module drive_reg_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request from the block
  input wire logic drv_req_valid,
  input wire logic [15:0] drv_req_addr,
  input wire logic [1:0] lat,
  // Answer to the block
  output logic drv_rsp_valid,
  output logic drv_rsp_error,
  output logic [15:0] drv_rsp_rdata
);
  logic busy_q;
  logic [1:0] cnt_q;
  logic [15:0] addr_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
      addr_q <= 16'h0000;
      drv_rsp_valid <= 1'b0;
      drv_rsp_error <= 1'b0;
      drv_rsp_rdata <= 16'h0000;
    end else begin
      drv_rsp_valid <= 1'b0;
      drv_rsp_error <= 1'b0;
      // Stale data flips so it never passes for an answer
      drv_rsp_rdata <= ~drv_rsp_rdata;
      if (drv_req_valid) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
        addr_q <= drv_req_addr;
      end else if (busy_q && cnt_q == 2'h0) begin
        busy_q <= 1'b0;
        drv_rsp_valid <= 1'b1;
        drv_rsp_error <= (addr_q == 16'hfffe);
        drv_rsp_rdata <= addr_q ^ 16'h5a3c;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule // drive_reg_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the Modbus slave local registers and response delay
`timescale 1ns/1ps
`default_nettype none
module tb_top import mb_local_pkg::*;;
  localparam int STEP = 4;
  localparam logic [7:0] FWV = 8'h3c; // Arbitrary value
  localparam logic [7:0] FWR = 8'h05; // Arbitrary value
  localparam logic [15:0] FA [9] = '{16'h0a01, 16'h0001, 16'h0c50, 16'h0c83, 16'h0fff,
    16'h1000, 16'hfc83, 16'hfbff, 16'hffff};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] dly, stn;
  logic frame_done, bad_packet, rsp_avail, tx_start, req_valid, req_ready, req_write;
  logic rsp_valid, rsp_error, drv_req_valid, drv_req_write, drv_rsp_valid, drv_rsp_error;
  logic ptr_restore_valid, nvm_wr_valid, mod_led_red, net_led_red;
  logic [15:0] req_addr, req_wdata, rsp_rdata, drv_req_addr, drv_req_wdata, drv_rsp_rdata;
  logic [15:0] ptr_restore_data, nvm_wr_data, v, d;
  logic [4:0] ptr_restore_idx, nvm_wr_idx, i;
  logic [1:0] lat;
  logic [15:0] tab [32];
  int miscompares = 0;
  int total_checks = 0;
  int unsigned seed = 6734;
  int c;
  always #5 clk = ~clk;
  modbus_slave_local_regs_delay #(.STEP_CYCLES_P(STEP), .FW_VERSION(FWV), .FW_REVISION(FWR))
  i_modbus_slave_local_regs_delay (.clk, .sys_rst, .response_delay_setting(dly),
    .station_number_setting(stn), .frame_done, .bad_packet, .rsp_avail, .tx_start, .req_valid,
    .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_error, .rsp_rdata,
    .drv_req_valid, .drv_req_write, .drv_req_addr, .drv_req_wdata, .drv_rsp_valid,
    .drv_rsp_error, .drv_rsp_rdata, .ptr_restore_valid, .ptr_restore_idx, .ptr_restore_data,
    .nvm_wr_valid, .nvm_wr_idx, .nvm_wr_data, .mod_led_red, .net_led_red);
  drive_reg_model i_drive_reg_model (.clk, .sys_rst, .drv_req_valid, .drv_req_addr, .lat,
    .drv_rsp_valid, .drv_rsp_error, .drv_rsp_rdata);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // Expected drive register for a forwarded address
  function automatic logic [15:0] drv_of(input logic [15:0] a);
    if (a[15:12] == 4'h0 && a[11:0] >= 12'hc40) return (a - 16'h0001) | 16'hf000;
    return a - 16'h0001;
  endfunction
  task automatic ex(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                    input logic ee, input logic [15:0] ed);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= wd;
    lat <= 2'(rnd());
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) miscompares++;
    check({15'h0000, rsp_error}, {15'h0000, ee});
    check(rsp_rdata, ed);
  endtask
  task automatic do_reset(input logic [7:0] ds, input logic [7:0] st);
    dly <= ds;
    stn <= st;
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Later setting changes must be ignored until the next reset
    dly <= ~ds;
  endtask
  task automatic tx_chk(input int late, input int exp);
    int k;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk);
      frame_done <= (k == 0);
      rsp_avail <= (k == late);
      @(negedge clk);
      if (tx_start === 1'b1) break;
    end
    @(posedge clk);
    frame_done <= 1'b0;
    rsp_avail <= 1'b0;
    check(16'(k), 16'(exp));
  endtask
  task automatic mod_cnt(output int cnt);
    cnt = 0;
    repeat (2 * MOD_BLINK_STEPS * STEP + 8) begin
      @(negedge clk);
      cnt += int'(mod_led_red);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {frame_done, bad_packet, rsp_avail, req_valid, req_write, ptr_restore_valid} = '0;
    {req_addr, req_wdata, ptr_restore_data, ptr_restore_idx, lat, dly, stn} = '0;
    do_reset(8'h02, 8'h00);
    mod_cnt(c);
    check(16'(c >= 180 && c <= 228), 16'h0001);
    tx_chk(0, 2 * STEP + 2);
    tx_chk(20, 22);
    @(posedge clk);
    bad_packet <= 1'b1;
    @(posedge clk);
    bad_packet <= 1'b0;
    @(negedge clk);
    check(16'(net_led_red), 16'h0001);
    repeat (NET_FLASH_STEPS * STEP + 2) @(negedge clk);
    check(16'(net_led_red), 16'h0000);
    $display("test delay and leds done");
    do_reset(8'hff, 8'hf7);
    mod_cnt(c);
    check(16'(c), 16'h0000);
    tx_chk(0, int'(DELAY_MAX_STEPS) * STEP + 2);
    do_reset(8'h00, 8'h01);
    tx_chk(0, 2);
    tx_chk(1, 3);
    $display("test clamp and zero delay done");
    ex(1'b0, 16'h0c82, 16'h0000, 1'b0, {FWV, FWR});
    ex(1'b0, 16'hfc82, 16'h0000, 1'b0, {FWV, FWR});
    ex(1'b1, 16'h0c82, 16'h1234, 1'b1, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      i = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'(rnd());
      v = {4'h1, 12'(rnd())};
      d = rnd();
      ex(1'b1, {k[0] ? 11'h7e1 : 11'h061, i}, v, 1'b0, 16'h0000);
      check({nvm_wr_valid, 10'h000, nvm_wr_idx}, {1'b1, 10'h000, i});
      check(nvm_wr_data, v);
      tab[i] = v;
      ex(1'b1, {11'h061, i}, 16'h0000, 1'b0 ^ 1'b1, 16'h0000);
      ex(1'b0, {11'h061, i}, 16'h0000, 1'b0, tab[i]);
      ex(1'b0, {11'h7e0, i}, 16'h0000, 1'b0, (tab[i] - 16'h0001) ^ 16'h5a3c);
      check(drv_req_addr, tab[i] - 16'h0001);
      // Forwarded writes hand back whatever the drive answers
      ex(1'b1, {11'h060, i}, d, 1'b0, (tab[i] - 16'h0001) ^ 16'h5a3c);
      check({drv_req_write, 15'h0000}, 16'h8000);
      check(drv_req_wdata, d);
    end
    ex(1'b1, 16'h0c22, 16'h0c05, 1'b0, 16'h0000);
    ex(1'b0, 16'h0c02, 16'h0000, 1'b1, 16'h0000);
    @(posedge clk);
    ptr_restore_valid <= 1'b1;
    ptr_restore_idx <= 5'h07;
    ptr_restore_data <= 16'h1a4e;
    @(posedge clk);
    ptr_restore_valid <= 1'b0;
    ex(1'b0, 16'hfc27, 16'h0000, 1'b0, 16'h1a4e);
    $display("test pointer registers done");
    foreach (FA[j]) begin
      // Drive register 0xFFFE is the one the model refuses
      v = drv_of(FA[j]);
      d = (v == 16'hfffe) ? 16'h0000 : v ^ 16'h5a3c;
      ex(1'b0, FA[j], 16'h0000, v == 16'hfffe, d);
      check(drv_req_addr, v);
    end
    ex(1'b0, 16'h0000, 16'h0000, 1'b1, 16'h0000);
    $display("test forwarding done");
    close_out();
  end
  initial begin
    // Whole run needs about 2100 cycles
    #(20000 * 10);
    miscompares++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
